// File: core/flash_seq_pkg.sv
// Opcodes, operation kinds, states and timing constants of the flash sequencer
package flash_seq_pkg;
	// Command opcodes
	localparam logic [7:0] OP_STATUS_WRITE     = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG        = 8'h02;
	localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
	localparam logic [7:0] OP_SECTOR_ERASE     = 8'h20;
	localparam logic [7:0] OP_QUAD_PROG        = 8'h32;
	localparam logic [7:0] OP_SECURITY_PROG    = 8'h42;
	localparam logic [7:0] OP_SECURITY_ERASE   = 8'h44;
	localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
	localparam logic [7:0] OP_CHIP_ERASE_ALT   = 8'h60;
	localparam logic [7:0] OP_SUSPEND          = 8'h75;
	localparam logic [7:0] OP_RESUME           = 8'h7a;
	localparam logic [7:0] OP_CHIP_ERASE       = 8'hc7;
	localparam logic [7:0] OP_FULL_BLOCK_ERASE = 8'hd8;

	// Frame layout in bytes
	localparam logic [2:0] LEN_OPCODE_ONLY = 3'h1;
	localparam logic [2:0] LEN_STATUS      = 3'h2;
	localparam logic [2:0] LEN_ADDRESSED   = 3'h4;
	localparam logic [2:0] LEN_MIN_PROG    = 3'h5;
	localparam logic [2:0] LEN_SATURATE    = 3'h7;
	localparam int         PAGE_BYTES      = 256;

	// Timing
	localparam int CLK_PERIOD_NS      = 4;
	localparam int SUSPEND_LATENCY_NS = 2000;
	localparam int SUSP_LATENCY_CYC   = (SUSPEND_LATENCY_NS / CLK_PERIOD_NS < 1) ? 1 :
		SUSPEND_LATENCY_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		KIND_NONE  = 3'h0,
		KIND_PROG  = 3'h1,
		KIND_SECT  = 3'h2,
		KIND_HALF  = 3'h3,
		KIND_FULL  = 3'h4,
		KIND_WHOLE = 3'h5
	} op_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'h0,
		ST_RUN       = 3'h1,
		ST_SUSP_WAIT = 3'h2,
		ST_SUSPENDED = 3'h3,
		ST_NESTED    = 3'h4
	} seq_state_t;
endpackage

// File: core/bit_sync.sv
// Two-flop level synchroniser for a group of independent bits
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// File: core/page_buffer.sv
// Page buffer: 256 bytes with per-byte valid bits, unwritten bytes read as ff
`timescale 1ns/1ns
`default_nettype none
module page_buffer (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       clr_in,
	input  wire logic       we_in,
	input  wire logic [7:0] waddr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic [7:0] raddr_in,
	output logic      [7:0] rdata_out
);
	logic [7:0]                            mem [flash_seq_pkg::PAGE_BYTES];
	logic [flash_seq_pkg::PAGE_BYTES-1:0]  valid_r;

	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
	end

	// Bytes never delivered stay ff, so they leave the array untouched
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			valid_r <= '0;
		end else if (clr_in) begin
			valid_r <= '0;
		end else if (we_in) begin
			valid_r[waddr_in] <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 8'hff;
		end else begin
			rdata_out <= valid_r[raddr_in] ? mem[raddr_in] : 8'hff;
		end
	end
endmodule
`default_nettype wire

// File: core/flash_program_erase_suspend.sv
// Program, erase and suspend command sequencer of a serial NOR flash
// Functional notes
// (RULE1) Quad page program runs only while quad lines enable is set.
// (RULE2) Host sends 32h, 24-bit address, data, all on four lines; the code takes 32h on one line, then address and data on four.
// (RULE3) Program writes up to 256 bytes; undelivered bytes stay erased ff.
// (RULE4) Program and erase refused unless write enable latch is set.
// (RULE5) Host holds chip select low until all data bytes are sent.
// (RULE6) 20h plus address erases one 4K sector to ff.
// (RULE7) 52h plus address erases one 32K block to ff.
// (RULE8) D8h plus address erases one 64K block to ff.
// (RULE9) C7h or 60h alone erases the whole array to ff.
// (RULE10) Erase runs only if chip select rises right after a byte boundary.
// (RULE11) Accepted erase starts a self-timed cycle of its kind's duration.
// (RULE12) Busy is 1 during a cycle, 0 after; then commands accepted.
// (RULE13) Completed program or erase clears the write enable latch.
// (RULE14) No erase of protected area; no chip erase if anything protected.
// (RULE15) Suspend accepted only when not suspended, busy, non-chip operation.
// (RULE16) Suspend during chip erase is ignored.
// (RULE17) During erase suspend, status write and erases are rejected.
// (RULE18) During program suspend, status write and programs are rejected.
// (RULE19) Accepted suspend sets suspend flag at once; busy falls within latency.
// (RULE20) Host waits the minimum interval after resume before suspending again.
// (RULE21) Power loss clears the suspend flag; suspended data may corrupt.
// (RULE22) Data beyond the page end wraps to the page start.
// (RULE23) Resume accepted only when suspended and idle; clears flag, sets busy.
// (RULE24) Busy holds from cycle start until completion or suspension.
`timescale 1ns/1ns
`default_nettype none
module flash_program_erase_suspend #(
	parameter int PAGE_PROGRAM_TIME_US    = 1000,
	parameter int SECTOR_ERASE_TIME_US    = 50000,
	parameter int HALF_BLOCK_ERASE_TIME_US = 100000,
	parameter int FULL_BLOCK_ERASE_TIME_US = 200000,
	parameter int WHOLE_ARRAY_ERASE_TIME_US = 1000000
) (
	// Clock and reset
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_IN,
	// Serial link
	input  wire logic        SCLK_IN,
	input  wire logic        CS_N_IN,
	input  wire logic [3:0]  SIO_IN,
	// Configuration and protection
	input  wire logic        QUAD_LINES_ENABLE_IN,
	input  wire logic        TARGET_PROTECTED_IN,
	input  wire logic        ANY_PROTECTED_IN,
	// Status
	output logic             BUSY_OUT,
	output logic             WRITE_ENABLE_LATCH_OUT,
	output logic             SUSPEND_FLAG_OUT,
	output logic             CMD_REJECT_OUT,
	output logic             STATUS_WRITE_OUT,
	output logic [7:0]       STATUS_DATA_OUT,
	output logic [23:0]      TARGET_ADDR_OUT,
	// Array side
	output logic             ARRAY_START_OUT,
	output logic             ARRAY_ACTIVE_OUT,
	output logic [2:0]       ARRAY_KIND_OUT,
	output logic [23:0]      ARRAY_ADDR_OUT,
	input  wire logic [7:0]  ARRAY_RD_ADDR_IN,
	output logic [7:0]       ARRAY_RD_DATA_OUT
);
	localparam int unsigned PROG_CYC  = PAGE_PROGRAM_TIME_US * 1000 / flash_seq_pkg::CLK_PERIOD_NS;
	localparam int unsigned SECT_CYC  = SECTOR_ERASE_TIME_US * 1000 / flash_seq_pkg::CLK_PERIOD_NS;
	localparam int unsigned HALF_CYC  = HALF_BLOCK_ERASE_TIME_US * 1000 /
		flash_seq_pkg::CLK_PERIOD_NS;
	localparam int unsigned FULL_CYC  = FULL_BLOCK_ERASE_TIME_US * 1000 /
		flash_seq_pkg::CLK_PERIOD_NS;
	localparam int unsigned WHOLE_CYC = WHOLE_ARRAY_ERASE_TIME_US * 1000 /
		flash_seq_pkg::CLK_PERIOD_NS;
	localparam logic [31:0] SUSP_CYC  = 32'(flash_seq_pkg::SUSP_LATENCY_CYC);

	// Link domain, clocked by the serial clock
	logic       lk_frame_r;
	logic       lk_quad_r;
	logic       lk_opc_done_r;
	logic [2:0] lk_bits_r;
	logic [7:0] lk_shift_r;
	logic [7:0] lk_byte_r;
	logic       lk_tgl_r;
	logic       lk_mid_r;
	logic       lk_quad_cur;
	logic [2:0] lk_bits_nxt;
	logic [7:0] lk_shift_nxt;
	logic       lk_rst;

	assign lk_rst = RST_IN | CS_N_IN;

	// Cleared while chip select is high, so the first edge of a frame starts fresh
	always_ff @(posedge SCLK_IN or posedge lk_rst) begin
		if (lk_rst) begin
			lk_frame_r <= 1'b0;
		end else begin
			lk_frame_r <= 1'b1;
		end
	end

	always_comb begin
		lk_quad_cur  = lk_frame_r & lk_quad_r;
		lk_shift_nxt = lk_quad_cur ? {lk_shift_r[3:0], SIO_IN} : {lk_shift_r[6:0], SIO_IN[0]};
		lk_bits_nxt  = lk_frame_r ? lk_bits_r : 3'h0;
		lk_bits_nxt  = lk_bits_nxt + (lk_quad_cur ? 3'h4 : 3'h1);
	end

	always_ff @(posedge SCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			lk_quad_r     <= 1'b0;
			lk_opc_done_r <= 1'b0;
			lk_bits_r     <= 3'h0;
			lk_shift_r    <= 8'h00;
			lk_byte_r     <= 8'h00;
			lk_tgl_r      <= 1'b0;
			lk_mid_r      <= 1'b0;
		end else begin
			lk_shift_r <= lk_shift_nxt;
			lk_bits_r  <= lk_bits_nxt;
			lk_mid_r   <= lk_bits_nxt != 3'h0;
			if (!lk_frame_r) begin
				lk_quad_r     <= 1'b0;
				lk_opc_done_r <= 1'b0;
			end
			if (lk_bits_nxt == 3'h0) begin
				lk_byte_r <= lk_shift_nxt;
				lk_tgl_r  <= ~lk_tgl_r;
				// Address and data go four lines wide after the quad opcode
				if (!(lk_frame_r && lk_opc_done_r)) begin
					lk_opc_done_r <= 1'b1;
					lk_quad_r     <= lk_shift_nxt == flash_seq_pkg::OP_QUAD_PROG; // RULE2
				end
			end
		end
	end

	// Crossing into the reference clock domain
	logic cs_s;
	logic cs_act_s;
	logic mid_s;
	logic tgl_s;
	logic cs_d_r;
	logic tgl_d_r;
	logic frame_end_r;
	logic byte_ev;
	logic cs_fall;

	// Select crosses active high so a reset synchroniser reads as deselected
	bit_sync #(.WIDTH(3)) u_sync (
		.clk_in   (REF_CLK_IN),
		.rst_in   (RST_IN),
		.async_in ({~CS_N_IN, lk_mid_r, lk_tgl_r}),
		.sync_out ({cs_act_s, mid_s, tgl_s})
	);

	assign cs_s    = ~cs_act_s;
	assign byte_ev = tgl_s ^ tgl_d_r;
	assign cs_fall = cs_d_r & ~cs_s;

	// Frame end handled one cycle late so the last byte toggle lands first
	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cs_d_r      <= 1'b1;
			tgl_d_r     <= 1'b0;
			frame_end_r <= 1'b0;
		end else begin
			cs_d_r      <= cs_s;
			tgl_d_r     <= tgl_s;
			frame_end_r <= cs_s & ~cs_d_r;
		end
	end

	// Frame assembly
	logic [2:0]  cnt_r;
	logic [7:0]  opc_r;
	logic [23:0] addr_r;
	logic [7:0]  wptr_r;
	logic [7:0]  stat_byte_r;

	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cnt_r       <= 3'h0;
			opc_r       <= 8'h00;
			addr_r      <= 24'h000000;
			wptr_r      <= 8'h00;
			stat_byte_r <= 8'h00;
		end else if (cs_fall) begin
			cnt_r  <= 3'h0;
			wptr_r <= 8'h00;
		end else if (byte_ev) begin
			if (cnt_r != flash_seq_pkg::LEN_SATURATE) begin
				cnt_r <= cnt_r + 3'h1;
			end
			if (cnt_r == 3'h0) begin
				opc_r <= lk_byte_r;
			end else if (cnt_r < flash_seq_pkg::LEN_ADDRESSED) begin
				addr_r <= {addr_r[15:0], lk_byte_r};
			end else begin
				wptr_r <= wptr_r + 8'h01; // RULE22
			end
			if (cnt_r == 3'h1) begin
				stat_byte_r <= lk_byte_r;
			end
		end
	end

	function automatic flash_seq_pkg::op_kind_t kind_of(input logic [7:0] op);
		case (op)
			flash_seq_pkg::OP_PAGE_PROG:        kind_of = flash_seq_pkg::KIND_PROG;
			flash_seq_pkg::OP_QUAD_PROG:        kind_of = flash_seq_pkg::KIND_PROG;
			flash_seq_pkg::OP_SECTOR_ERASE:     kind_of = flash_seq_pkg::KIND_SECT; // RULE6
			flash_seq_pkg::OP_HALF_BLOCK_ERASE: kind_of = flash_seq_pkg::KIND_HALF; // RULE7
			flash_seq_pkg::OP_FULL_BLOCK_ERASE: kind_of = flash_seq_pkg::KIND_FULL; // RULE8
			flash_seq_pkg::OP_CHIP_ERASE:       kind_of = flash_seq_pkg::KIND_WHOLE; // RULE9
			flash_seq_pkg::OP_CHIP_ERASE_ALT:   kind_of = flash_seq_pkg::KIND_WHOLE; // RULE9
			default:                            kind_of = flash_seq_pkg::KIND_NONE;
		endcase
	endfunction

	function automatic logic is_erase_op(input logic [7:0] op);
		is_erase_op = (kind_of(op) > flash_seq_pkg::KIND_PROG) ||
			(op == flash_seq_pkg::OP_SECURITY_ERASE);
	endfunction

	function automatic logic is_prog_op(input logic [7:0] op);
		is_prog_op = (kind_of(op) == flash_seq_pkg::KIND_PROG) ||
			(op == flash_seq_pkg::OP_SECURITY_PROG);
	endfunction

	function automatic logic [31:0] dur_of(input flash_seq_pkg::op_kind_t k);
		case (k)
			flash_seq_pkg::KIND_PROG:  dur_of = 32'(PROG_CYC);
			flash_seq_pkg::KIND_SECT:  dur_of = 32'(SECT_CYC);
			flash_seq_pkg::KIND_HALF:  dur_of = 32'(HALF_CYC);
			flash_seq_pkg::KIND_FULL:  dur_of = 32'(FULL_CYC);
			default:                   dur_of = 32'(WHOLE_CYC);
		endcase
	endfunction

	// Sequencer state
	flash_seq_pkg::seq_state_t state_r;
	flash_seq_pkg::seq_state_t state_nxt;
	flash_seq_pkg::op_kind_t   kind_r;
	flash_seq_pkg::op_kind_t   nest_kind_r;
	flash_seq_pkg::op_kind_t   new_kind;
	logic [31:0] timer_r;
	logic [31:0] saved_r;
	logic [23:0] prim_addr_r;
	logic [23:0] nest_addr_r;
	logic        wel_r;
	logic        busy;
	logic        suspend_flag;
	logic        aligned;
	logic        len_ok;
	logic        class_ok;
	logic        go;
	logic        do_susp;
	logic        do_res;
	logic        wel_set;
	logic        stat_wr;
	logic        reject;
	logic        done;
	logic        buf_locked;

	assign busy    = state_r == flash_seq_pkg::ST_RUN || state_r == flash_seq_pkg::ST_SUSP_WAIT ||
		state_r == flash_seq_pkg::ST_NESTED;
	assign suspend_flag     = state_r == flash_seq_pkg::ST_SUSP_WAIT ||
		state_r == flash_seq_pkg::ST_SUSPENDED || state_r == flash_seq_pkg::ST_NESTED;
	assign aligned = ~mid_s;
	assign done    = (state_r == flash_seq_pkg::ST_RUN || state_r == flash_seq_pkg::ST_NESTED) &&
		timer_r == 32'h1;
	assign buf_locked = (busy && kind_r == flash_seq_pkg::KIND_PROG) ||
		(state_r == flash_seq_pkg::ST_NESTED && nest_kind_r == flash_seq_pkg::KIND_PROG) ||
		(suspend_flag && kind_r == flash_seq_pkg::KIND_PROG);

	// Command decode at the end of each frame
	always_comb begin
		new_kind = kind_of(opc_r);
		go       = 1'b0;
		do_susp  = 1'b0;
		do_res   = 1'b0;
		wel_set  = 1'b0;
		stat_wr  = 1'b0;
		reject   = 1'b0;
		len_ok   = 1'b0;
		class_ok = 1'b0;
		if (frame_end_r && cnt_r != 3'h0) begin
			case (opc_r)
				flash_seq_pkg::OP_WRITE_ENABLE: begin
					wel_set = cnt_r == flash_seq_pkg::LEN_OPCODE_ONLY && aligned && !busy;
					reject  = !wel_set;
				end
				flash_seq_pkg::OP_SUSPEND: begin
					do_susp = state_r == flash_seq_pkg::ST_RUN &&
						kind_r != flash_seq_pkg::KIND_WHOLE; // RULE15 RULE16
					reject  = !do_susp;
				end
				flash_seq_pkg::OP_RESUME: begin
					do_res = state_r == flash_seq_pkg::ST_SUSPENDED; // RULE23
					reject = !do_res;
				end
				flash_seq_pkg::OP_STATUS_WRITE: begin
					stat_wr = cnt_r == flash_seq_pkg::LEN_STATUS && aligned && wel_r &&
						!busy && !suspend_flag; // RULE17 RULE18
					reject  = !stat_wr;
				end
				default: begin
					case (new_kind)
						flash_seq_pkg::KIND_WHOLE: len_ok = cnt_r == flash_seq_pkg::LEN_OPCODE_ONLY;
						flash_seq_pkg::KIND_PROG:  len_ok = cnt_r >= flash_seq_pkg::LEN_MIN_PROG;
						default:                   len_ok = cnt_r == flash_seq_pkg::LEN_ADDRESSED;
					endcase
					class_ok = !(suspend_flag && is_erase_op(kind_r == flash_seq_pkg::KIND_PROG ?
						flash_seq_pkg::OP_PAGE_PROG : flash_seq_pkg::OP_SECTOR_ERASE) &&
						is_erase_op(opc_r)) && // RULE17
						!(suspend_flag && kind_r == flash_seq_pkg::KIND_PROG && is_prog_op(opc_r)); // RULE18
					go = new_kind != flash_seq_pkg::KIND_NONE && len_ok && aligned && // RULE10
						wel_r && // RULE4
						(opc_r != flash_seq_pkg::OP_QUAD_PROG || QUAD_LINES_ENABLE_IN) && // RULE1
						(state_r == flash_seq_pkg::ST_IDLE || state_r == flash_seq_pkg::ST_SUSPENDED) &&
						class_ok &&
						(new_kind == flash_seq_pkg::KIND_WHOLE ? !ANY_PROTECTED_IN :
						!TARGET_PROTECTED_IN); // RULE14
					reject = !go;
				end
			endcase
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			flash_seq_pkg::ST_IDLE:      if (go) state_nxt = flash_seq_pkg::ST_RUN; // RULE11
			flash_seq_pkg::ST_RUN: begin
				if (done) begin
					state_nxt = flash_seq_pkg::ST_IDLE;
				end else if (do_susp) begin
					state_nxt = flash_seq_pkg::ST_SUSP_WAIT;
				end
			end
			flash_seq_pkg::ST_SUSP_WAIT: if (timer_r == 32'h1) state_nxt = flash_seq_pkg::ST_SUSPENDED;
			flash_seq_pkg::ST_SUSPENDED: begin
				if (do_res) begin
					state_nxt = flash_seq_pkg::ST_RUN;
				end else if (go) begin
					state_nxt = flash_seq_pkg::ST_NESTED;
				end
			end
			flash_seq_pkg::ST_NESTED:    if (done) state_nxt = flash_seq_pkg::ST_SUSPENDED;
			default:                     state_nxt = flash_seq_pkg::ST_IDLE;
		endcase
	end

	// Reset stands for power loss: any suspension is dropped
	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_r <= flash_seq_pkg::ST_IDLE; // RULE21
		end else begin
			state_r <= state_nxt; // RULE24
		end
	end

	// Operation timer; a suspended cycle keeps its remaining time in saved_r
	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			timer_r     <= 32'h0;
			saved_r     <= 32'h0;
			kind_r      <= flash_seq_pkg::KIND_NONE;
			nest_kind_r <= flash_seq_pkg::KIND_NONE;
			prim_addr_r <= 24'h000000;
			nest_addr_r <= 24'h000000;
		end else if (go && state_r == flash_seq_pkg::ST_IDLE) begin
			timer_r     <= dur_of(new_kind); // RULE11
			kind_r      <= new_kind;
			prim_addr_r <= addr_r;
		end else if (go) begin
			saved_r     <= timer_r;
			timer_r     <= dur_of(new_kind);
			nest_kind_r <= new_kind;
			nest_addr_r <= addr_r;
		end else if (do_susp) begin
			saved_r <= timer_r;
			timer_r <= SUSP_CYC; // RULE19
		end else if (state_r == flash_seq_pkg::ST_SUSP_WAIT && timer_r == 32'h1) begin
			timer_r <= saved_r;
		end else if (done && state_r == flash_seq_pkg::ST_NESTED) begin
			timer_r <= saved_r;
		end else if (busy && timer_r != 32'h0) begin
			timer_r <= timer_r - 32'h1;
		end
	end

	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			wel_r <= 1'b0;
		end else if (wel_set) begin
			wel_r <= 1'b1;
		end else if (done) begin
			wel_r <= 1'b0; // RULE13
		end
	end

	page_buffer u_page (
		.clk_in    (REF_CLK_IN),
		.rst_in    (RST_IN),
		.clr_in    (cs_fall && !buf_locked),
		.we_in     (byte_ev && !cs_fall && cnt_r >= flash_seq_pkg::LEN_ADDRESSED &&
			kind_of(opc_r) == flash_seq_pkg::KIND_PROG && !buf_locked), // RULE3
		.waddr_in  (addr_r[7:0] + wptr_r), // RULE22
		.wdata_in  (lk_byte_r),
		.raddr_in  (ARRAY_RD_ADDR_IN),
		.rdata_out (ARRAY_RD_DATA_OUT)
	);

	// Registered outputs; busy, suspend flag and array active are decoded from the next state so they track state_r
	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			BUSY_OUT               <= 1'b0;
			SUSPEND_FLAG_OUT       <= 1'b0;
			WRITE_ENABLE_LATCH_OUT <= 1'b0;
			CMD_REJECT_OUT         <= 1'b0;
			STATUS_WRITE_OUT       <= 1'b0;
			STATUS_DATA_OUT        <= 8'h00;
			TARGET_ADDR_OUT        <= 24'h000000;
			ARRAY_START_OUT        <= 1'b0;
			ARRAY_ACTIVE_OUT       <= 1'b0;
			ARRAY_KIND_OUT         <= 3'h0;
			ARRAY_ADDR_OUT         <= 24'h000000;
		end else begin
			BUSY_OUT <= state_nxt == flash_seq_pkg::ST_RUN || // RULE12
				state_nxt == flash_seq_pkg::ST_SUSP_WAIT || state_nxt == flash_seq_pkg::ST_NESTED;
			SUSPEND_FLAG_OUT <= state_nxt == flash_seq_pkg::ST_SUSP_WAIT ||
				state_nxt == flash_seq_pkg::ST_SUSPENDED || state_nxt == flash_seq_pkg::ST_NESTED;
			WRITE_ENABLE_LATCH_OUT <= wel_set ? 1'b1 : (done ? 1'b0 : wel_r);
			CMD_REJECT_OUT   <= reject;
			STATUS_WRITE_OUT <= stat_wr;
			if (stat_wr) begin
				STATUS_DATA_OUT <= stat_byte_r;
			end
			TARGET_ADDR_OUT  <= addr_r;
			ARRAY_START_OUT  <= go;
			ARRAY_ACTIVE_OUT <= state_nxt == flash_seq_pkg::ST_RUN ||
				state_nxt == flash_seq_pkg::ST_NESTED;
			if (go) begin
				ARRAY_KIND_OUT <= new_kind;
				ARRAY_ADDR_OUT <= addr_r;
			end else if (state_nxt == flash_seq_pkg::ST_RUN) begin
				ARRAY_KIND_OUT <= kind_r;
				ARRAY_ADDR_OUT <= prim_addr_r;
			end
		end
	end

	localparam int susp_bound = flash_seq_pkg::SUSP_LATENCY_CYC + 2;

	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (RST_IN);

	sequence s_suspend_taken;
		do_susp ##1 SUSPEND_FLAG_OUT && BUSY_OUT;
	endsequence

	chk_busy_while_run: assert property (state_r == flash_seq_pkg::ST_RUN |-> BUSY_OUT) // RULE24
		else $error("busy low while a cycle runs");
	chk_busy_done_low: assert property (done && state_r == flash_seq_pkg::ST_RUN |=> !BUSY_OUT) // RULE12
		else $error("busy stays high after completion");
	chk_wel_cleared: assert property (done |=> !WRITE_ENABLE_LATCH_OUT) // RULE13
		else $error("write enable latch not cleared at completion");
	chk_start_needs_wel: assert property (ARRAY_START_OUT |-> $past(wel_r)) // RULE4
		else $error("operation started without write enable");
	chk_quad_needs_enable: assert property (go && opc_r == flash_seq_pkg::OP_QUAD_PROG
		|-> QUAD_LINES_ENABLE_IN) // RULE1
		else $error("quad program without quad enable");
	chk_erase_exact_end: assert property (go && new_kind != flash_seq_pkg::KIND_PROG
		|-> aligned && cnt_r <= flash_seq_pkg::LEN_ADDRESSED) // RULE10
		else $error("erase taken from a malformed frame");
	chk_no_protected_erase: assert property (go && new_kind == flash_seq_pkg::KIND_WHOLE
		|-> !ANY_PROTECTED_IN) // RULE14
		else $error("chip erase despite protection");
	chk_chip_no_suspend: assert property (state_r == flash_seq_pkg::ST_RUN &&
		kind_r == flash_seq_pkg::KIND_WHOLE |=> state_r != flash_seq_pkg::ST_SUSP_WAIT) // RULE16
		else $error("chip erase was suspended");
	chk_suspend_flag_now: assert property (do_susp |-> s_suspend_taken) // RULE19
		else $error("suspend flag not set at once");
	chk_suspend_busy_falls: assert property (do_susp |-> ##[1:susp_bound] !BUSY_OUT) // RULE19
		else $error("busy did not fall within suspend latency");
	chk_resume_sets_busy: assert property (do_res |=> BUSY_OUT && !SUSPEND_FLAG_OUT) // RULE23
		else $error("resume did not restore busy");
	chk_erase_in_suspend: assert property (go && suspend_flag && kind_r != flash_seq_pkg::KIND_PROG
		|-> !is_erase_op(opc_r)) // RULE17
		else $error("erase accepted during erase suspend");
endmodule
`default_nettype wire

// File: test/spi_host_model.sv
// Host serial controller model that drives command frames into the sequencer
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	output logic       sclk_out,
	output logic       cs_n_out,
	output logic [3:0] sio_out
);
	logic [7:0] tx[$];

	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sio_out  = 4'h5;
	end

	// Bytes from index qf onward go as nibbles; cut drops trailing edges
	task automatic send(input int qf, input int cut);
		logic [3:0] e[$];
		foreach (tx[i])
			if (i >= qf) e = {e, tx[i][7:4], tx[i][3:0]};
			else for (int k = 7; k >= 0; k--) e.push_back({3'h0, tx[i][k]});
		#7 cs_n_out = 1'b0;
		for (int j = 0; j < e.size() - cut; j++) begin
			sio_out = e[j];
			#32 sclk_out = 1'b1;
			#32 sclk_out = 1'b0;
		end
		#16 cs_n_out = 1'b1;
		// Released lines must not keep the last value
		sio_out = ~sio_out;
		tx.delete();
		#400;
	endtask
endmodule
`default_nettype wire

// File: test/flash_program_erase_suspend_tb.sv
// Self-checking bench for the flash program, erase and suspend sequencer
`timescale 1ns/1ns
`default_nettype none
module flash_program_erase_suspend_tb;
	logic        clk, rst, qe, tprot, aprot, sclk, cs_n, busy, write_enable_latch, suspend_flag, rej, start, act;
	logic [3:0]  sio;
	logic [2:0]  kind;
	logic [23:0] aaddr, addr, taddr;
	logic [7:0]  rd_addr, rd_data;
	logic [7:0]  dq[$];
	logic [7:0]  ops[5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
	logic [2:0]  kinds[5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h5};
	int          errors, n_tests, cyc, n_rej, n_start, x_rej, x_start;

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	spi_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .sio_out(sio));

	flash_program_erase_suspend #(
		.PAGE_PROGRAM_TIME_US(1), .SECTOR_ERASE_TIME_US(4), .HALF_BLOCK_ERASE_TIME_US(1),
		.FULL_BLOCK_ERASE_TIME_US(1), .WHOLE_ARRAY_ERASE_TIME_US(4)
	) dut (
		.REF_CLK_IN(clk), .RST_IN(rst), .SCLK_IN(sclk), .CS_N_IN(cs_n), .SIO_IN(sio),
		.QUAD_LINES_ENABLE_IN(qe), .TARGET_PROTECTED_IN(tprot), .ANY_PROTECTED_IN(aprot),
		.BUSY_OUT(busy), .WRITE_ENABLE_LATCH_OUT(write_enable_latch), .SUSPEND_FLAG_OUT(suspend_flag),
		.CMD_REJECT_OUT(rej), .STATUS_WRITE_OUT(), .STATUS_DATA_OUT(), .TARGET_ADDR_OUT(taddr),
		.ARRAY_START_OUT(start), .ARRAY_ACTIVE_OUT(act), .ARRAY_KIND_OUT(kind),
		.ARRAY_ADDR_OUT(aaddr), .ARRAY_RD_ADDR_IN(rd_addr), .ARRAY_RD_DATA_OUT(rd_data)
	);

	// One-cycle pulses are tallied here and compared with the expected tallies x_start plus one and x_rej
	always @(posedge clk) begin
		cyc++;
		n_rej += (rej === 1'b1);
		n_start += (start === 1'b1);
		if (cyc == 80000) begin
			errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (errors == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic st(input logic [2:0] exp);
		chk("busy_wel_sus", {21'h0, exp}, {21'h0, busy, write_enable_latch, suspend_flag});
	endtask

	task automatic frm(input logic [7:0] op, input bit ad, input int cut = 0, input int qf = 99);
		host.tx = {op};
		if (ad) host.tx = {host.tx, addr[23:16], addr[15:8], addr[7:0]};
		host.tx = {host.tx, dq};
		host.send(qf, cut);
		@(posedge clk) #1;
	endtask

	task automatic idle();
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
		#1;
	endtask

	task automatic we();
		frm(flash_seq_pkg::OP_WRITE_ENABLE, 0);
		st(3'b010);
	endtask

	initial begin
		rst = 1'b1;
		qe = 1'b0;
		tprot = 1'b0;
		aprot = 1'b0;
		rd_addr = 8'h00;
		addr = 24'h0;
		void'($urandom(39724));
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk);
		frm(ops[0], 1);
		x_rej++;
		st(3'b000);
		for (int i = 0; i < 5; i++) begin
			addr = 24'($urandom);
			we();
			frm(ops[i], i < 3);
			x_start++;
			st(3'b110);
			chk("kind", 24'(kinds[i]), 24'(kind));
			if (i < 3) chk("addr", addr, aaddr);
			if (i < 3) chk("taddr", addr, taddr);
			chk("active", 24'h1, 24'(act));
			idle();
			st(3'b000);
		end
		we();
		frm(ops[0], 1, 3);
		tprot = 1'b1;
		frm(ops[0], 1);
		tprot = 1'b0;
		aprot = 1'b1;
		frm(ops[3], 0);
		aprot = 1'b0;
		addr = {16'($urandom), 8'hff};
		dq = {8'($urandom), 8'($urandom), 8'($urandom)};
		frm(flash_seq_pkg::OP_QUAD_PROG, 1, 0, 1);
		x_rej += 4;
		qe = 1'b1;
		frm(flash_seq_pkg::OP_QUAD_PROG, 1, 0, 1);
		x_start++;
		chk("kind", 24'h1, 24'(kind));
		for (int j = 0; j < 4; j++) begin
			rd_addr = 8'hff + 8'(j);
			@(posedge clk) #1;
			chk("page", j < 3 ? 24'(dq[j]) : 24'hff, 24'(rd_data));
		end
		dq.delete();
		idle();
		st(3'b000);
		we();
		frm(ops[0], 1);
		frm(flash_seq_pkg::OP_SUSPEND, 0);
		st(3'b111);
		chk("active", 24'h0, 24'(act));
		idle();
		st(3'b011);
		frm(ops[1], 1);
		frm(flash_seq_pkg::OP_RESUME, 0);
		st(3'b110);
		chk("active", 24'h1, 24'(act));
		idle();
		we();
		frm(ops[3], 0);
		frm(flash_seq_pkg::OP_SUSPEND, 0);
		st(3'b110);
		idle();
		x_rej += 2;
		x_start += 2;
		we();
		frm(ops[0], 1);
		frm(flash_seq_pkg::OP_SUSPEND, 0);
		rst = 1'b1;
		repeat (3) @(posedge clk);
		st(3'b000);
		chk("starts", 24'(x_start + 1), 24'(n_start));
		chk("rejects", 24'(x_rej), 24'(n_rej));
		complete_run();
	end
endmodule
`default_nettype wire
